// [hdl/cacd_pkg.sv]
// Function
// - clear_operand writes zero; B0 register, B1 indirect; 2 bytes; flags kept
// - invert_operand inverts destination; 60/61; sets Z,S; clears V; keeps C
// - compare subtracts without storing; A2..A7 operand forms; updates C,Z,S,V
// - compare_with_carry also subtracts carry; prefix 1F adds one fetch byte
// - compare_extended A8 (ER,ER) or A9 (ER,IM); 4 bytes, 3 cycles
// - compare_carry_extended 1F A8/1F A9; 5 bytes, 3 cycles, updates C,Z,S,V
// - decimal_adjust 40/41 corrects to packed decimal; updates C,Z,S
// - subtract_one 30/31 decrements byte; updates Z,S,V; carry kept
// - subtract_one_word 80/81 decrements pair; 5/6 cycles; Z,S,V; carry kept
package cacd_pkg;
  // one-hot sequencer states
  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10
  } cacd_state_e;
  typedef enum logic [2:0] {
    AOP_NONE, AOP_CLR, AOP_COM, AOP_CP, AOP_CPC, AOP_DA, AOP_DEC, AOP_SUBTRACT_ONE_WORD
  } cacd_aop_e;
  // opcodes
  localparam logic [7:0] OPC_PFX = 8'h1F;
  localparam logic [7:0] OPC_CLR_R = 8'hB0;
  localparam logic [7:0] OPC_CLR_IR = 8'hB1;
  localparam logic [7:0] OPC_COM_R = 8'h60;
  localparam logic [7:0] OPC_COM_IR = 8'h61;
  localparam logic [7:0] OPC_CP_RR = 8'hA2;
  localparam logic [7:0] OPC_CP_RIR = 8'hA3;
  localparam logic [7:0] OPC_CP_R_R = 8'hA4;
  localparam logic [7:0] OPC_CP_R_IR = 8'hA5;
  localparam logic [7:0] OPC_CP_R_IM = 8'hA6;
  localparam logic [7:0] OPC_CP_IR_IM = 8'hA7;
  localparam logic [7:0] OPC_CPX_ER = 8'hA8;
  localparam logic [7:0] OPC_CPX_IM = 8'hA9;
  localparam logic [7:0] OPC_DA_R = 8'h40;
  localparam logic [7:0] OPC_DA_IR = 8'h41;
  localparam logic [7:0] OPC_DEC_R = 8'h30;
  localparam logic [7:0] OPC_DEC_IR = 8'h31;
  localparam logic [7:0] OPC_SUBTRACT_ONE_WORD_RR = 8'h80;
  localparam logic [7:0] OPC_SUBTRACT_ONE_WORD_IRR = 8'h81;
  localparam logic [7:0] OPC_DI = 8'h8F;
  // fetch byte counts without prefix
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_X = 3'h4;
  // execution cycle counts
  localparam logic [2:0] CYC_R = 3'h2;
  localparam logic [2:0] CYC_IR = 3'h3;
  localparam logic [2:0] CYC_CP = 3'h3;
  localparam logic [2:0] CYC_CP_I = 3'h4;
  localparam logic [2:0] CYC_CPX = 3'h3;
  localparam logic [2:0] CYC_SUBTRACT_ONE_WORD = 3'h5;
  localparam logic [2:0] CYC_SUBTRACT_ONE_WORD_I = 3'h6;
  localparam logic [2:0] CYC_DI = 3'h2;
  // flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam int IRQ_EN_BIT = 7;
  // working registers live in this page of the register file
  localparam logic [3:0] WORK_PAGE = 4'hE;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  // decimal adjust constants
  localparam logic [7:0] DA_LO = 8'h06;
  localparam logic [7:0] DA_HI = 8'h60;
  localparam logic [3:0] DA_NIB_MAX = 4'h9;
  localparam logic [7:0] DA_BYTE_MAX = 8'h99;
  localparam logic [7:0] MIN_BYTE = 8'h80;
  localparam logic [15:0] MIN_WORD = 16'h8000;
endpackage

// [hdl/cacd_alu_if.sv]
`timescale 1ns/1ns
// operands from the sequencer to the arithmetic unit and its results
interface cacd_alu_if;
  import cacd_pkg::*;
  cacd_aop_e aop;
  logic [7:0] dst;
  logic [7:0] src;
  logic [15:0] wdst;
  logic [7:0] fin;
  logic [7:0] res;
  logic [15:0] wres;
  logic [7:0] fout;
  logic wr;
  modport core (output aop, dst, src, wdst, fin, input res, wres, fout, wr);
  modport alu (input aop, dst, src, wdst, fin, output res, wres, fout, wr);
endinterface

// [hdl/cacd_alu.sv]
`timescale 1ns/1ns
module cacd_alu (
  cacd_alu_if.alu a
);
  import cacd_pkg::*;
  // one operation per commit; flags not named by an operation pass through
  always_comb begin
    logic [8:0] diff;
    logic [7:0] t;
    diff = 9'h000;
    t = 8'h00;
    a.res = a.dst;
    a.wres = a.wdst;
    a.fout = a.fin;
    a.wr = 1'b0;
    case (a.aop)
      AOP_CLR: begin
        a.res = 8'h00;
        a.wr = 1'b1;
      end
      AOP_COM: begin
        a.res = ~a.dst;
        a.fout[FLAG_Z] = (a.res == 8'h00);
        a.fout[FLAG_S] = a.res[7];
        a.fout[FLAG_V] = 1'b0;
        a.wr = 1'b1;
      end
      AOP_CP, AOP_CPC: begin
        // borrow chain; the carry term only joins for the carry form
        diff = {1'b0, a.dst} - {1'b0, a.src}
             - {8'h00, (a.aop == AOP_CPC) & a.fin[FLAG_C]};
        a.res = diff[7:0];
        a.fout[FLAG_C] = diff[8];
        a.fout[FLAG_Z] = (diff[7:0] == 8'h00);
        a.fout[FLAG_S] = diff[7];
        a.fout[FLAG_V] = (a.dst[7] != a.src[7]) && (diff[7] != a.dst[7]);
      end
      AOP_DA: begin
        // D selects the correction direction of the last add or subtract
        t = a.dst;
        a.fout[FLAG_C] = a.fin[FLAG_C];
        if (!a.fin[FLAG_D]) begin
          if (a.fin[FLAG_C] || (a.dst > DA_BYTE_MAX)) begin
            t = t + DA_HI;
            a.fout[FLAG_C] = 1'b1;
          end
          if (a.fin[FLAG_H] || (a.dst[3:0] > DA_NIB_MAX)) begin
            t = t + DA_LO;
          end
        end else begin
          if (a.fin[FLAG_C]) begin
            t = t - DA_HI;
          end
          if (a.fin[FLAG_H]) begin
            t = t - DA_LO;
          end
        end
        a.res = t;
        a.fout[FLAG_Z] = (t == 8'h00);
        a.fout[FLAG_S] = t[7];
        a.wr = 1'b1;
      end
      AOP_DEC: begin
        a.res = a.dst - 8'h01;
        a.fout[FLAG_Z] = (a.res == 8'h00);
        a.fout[FLAG_S] = a.res[7];
        a.fout[FLAG_V] = (a.dst == MIN_BYTE);
        a.wr = 1'b1;
      end
      AOP_SUBTRACT_ONE_WORD: begin
        a.wres = a.wdst - 16'h0001;
        a.fout[FLAG_Z] = (a.wres == 16'h0000);
        a.fout[FLAG_S] = a.wres[15];
        a.fout[FLAG_V] = (a.wdst == MIN_WORD);
        a.wr = 1'b1;
      end
      default: begin
        a.wr = 1'b0;
      end
    endcase
  end
endmodule

// [hdl/cacd_core.sv]
`timescale 1ns/1ns
module cacd_core (
  input wire logic clock,
  input wire logic reset_n,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_data,
  input wire logic fetch_ack,
  input wire logic load_we,
  input wire logic [7:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic irq_enable_set,
  input wire logic [7:0] peek_addr,
  output logic [7:0] peek_data,
  output logic [7:0] flags,
  output logic [7:0] interrupt_control_reg,
  output logic instr_done,
  output logic illegal_op
);
  import cacd_pkg::*;

  typedef struct packed {
    cacd_state_e st;
    logic [15:0] pc;
    logic pfx;
    logic have_op;
    logic [7:0] op;
    logic [2:0][7:0] opr;
    logic [2:0] nb;
    logic [2:0] cnt;
    logic [7:0] flags;
    logic [7:0] irq_ctl;
    logic done;
    logic illegal;
    logic [7:0] peek;
    logic [255:0][7:0] mem;
  } cacd_core_s;

  cacd_core_s s;
  cacd_core_s next_s;
  cacd_alu_if alu_bus ();
  logic commit;
  logic [7:0] dst_a;
  logic [7:0] pair_a;

  // total fetch bytes; zero marks an opcode this block does not execute
  function automatic logic [2:0] f_len(logic p, logic [7:0] o);
    logic [2:0] n;
    n = 3'h0;
    case (o)
      OPC_CP_RR, OPC_CP_RIR: n = LEN_2;
      OPC_CP_R_R, OPC_CP_R_IR, OPC_CP_R_IM, OPC_CP_IR_IM: n = LEN_3;
      OPC_CPX_ER, OPC_CPX_IM: n = LEN_X;
      OPC_CLR_R, OPC_CLR_IR, OPC_COM_R, OPC_COM_IR, OPC_DA_R, OPC_DA_IR,
      OPC_DEC_R, OPC_DEC_IR, OPC_SUBTRACT_ONE_WORD_RR, OPC_SUBTRACT_ONE_WORD_IRR: n = p ? 3'h0 : LEN_2;
      OPC_DI: n = p ? 3'h0 : LEN_1;
      default: n = 3'h0;
    endcase
    // the prefix costs one more byte for every compare form
    return (n != 3'h0 && p) ? n + 3'h1 : n;
  endfunction

  function automatic logic [2:0] f_cyc(logic [7:0] o);
    case (o)
      OPC_CLR_R, OPC_COM_R, OPC_DA_R, OPC_DEC_R: return CYC_R;
      OPC_CLR_IR, OPC_COM_IR, OPC_DA_IR, OPC_DEC_IR: return CYC_IR;
      OPC_CP_RIR, OPC_CP_R_IR, OPC_CP_IR_IM: return CYC_CP_I;
      OPC_CPX_ER, OPC_CPX_IM: return CYC_CPX;
      OPC_SUBTRACT_ONE_WORD_RR: return CYC_SUBTRACT_ONE_WORD;
      OPC_SUBTRACT_ONE_WORD_IRR: return CYC_SUBTRACT_ONE_WORD_I;
      OPC_DI: return CYC_DI;
      default: return CYC_CP;
    endcase
  endfunction

  function automatic cacd_aop_e f_aop(logic p, logic [7:0] o);
    case (o)
      OPC_CLR_R, OPC_CLR_IR: return AOP_CLR;
      OPC_COM_R, OPC_COM_IR: return AOP_COM;
      OPC_DA_R, OPC_DA_IR: return AOP_DA;
      OPC_DEC_R, OPC_DEC_IR: return AOP_DEC;
      OPC_SUBTRACT_ONE_WORD_RR, OPC_SUBTRACT_ONE_WORD_IRR: return AOP_SUBTRACT_ONE_WORD;
      OPC_DI: return AOP_NONE;
      default: return p ? AOP_CPC : AOP_CP;
    endcase
  endfunction

  function automatic logic [7:0] f_wk(logic [3:0] n);
    return {WORK_PAGE, n};
  endfunction

  assign commit = (s.st == ST_EXEC) && (s.cnt == 3'h1);

  // operand resolution; extended addresses keep only their low byte
  always_comb begin
    logic [7:0] sv;
    sv = 8'h00;
    dst_a = s.opr[0];
    pair_a = {s.opr[0][7:1], 1'b0};
    case (s.op)
      OPC_CLR_IR, OPC_COM_IR, OPC_DA_IR, OPC_DEC_IR: dst_a = s.mem[s.opr[0]];
      OPC_SUBTRACT_ONE_WORD_IRR: pair_a = {s.mem[s.opr[0]][7:1], 1'b0};
      OPC_CP_RR: begin
        dst_a = f_wk(s.opr[0][7:4]);
        sv = s.mem[f_wk(s.opr[0][3:0])];
      end
      OPC_CP_RIR: begin
        dst_a = f_wk(s.opr[0][7:4]);
        sv = s.mem[s.mem[f_wk(s.opr[0][3:0])]];
      end
      OPC_CP_R_R: begin
        dst_a = s.opr[1];
        sv = s.mem[s.opr[0]];
      end
      OPC_CP_R_IR: begin
        dst_a = s.opr[1];
        sv = s.mem[s.mem[s.opr[0]]];
      end
      OPC_CP_R_IM: sv = s.opr[1];
      OPC_CP_IR_IM: begin
        dst_a = s.mem[s.opr[0]];
        sv = s.opr[1];
      end
      OPC_CPX_ER: begin
        dst_a = s.opr[2];
        sv = s.mem[{s.opr[0][3:0], s.opr[1][7:4]}];
      end
      OPC_CPX_IM: begin
        dst_a = s.opr[2];
        sv = s.opr[0];
      end
      default: sv = 8'h00;
    endcase
    alu_bus.aop = f_aop(s.pfx, s.op);
    alu_bus.dst = s.mem[dst_a];
    alu_bus.src = sv;
    alu_bus.wdst = {s.mem[pair_a], s.mem[pair_a | 8'h01]};
    alu_bus.fin = s.flags;
  end

  cacd_alu u_alu (
    .a(alu_bus.alu)
  );

  // sequencer: collect bytes, wait out the cycle count, then commit
  always_comb begin
    logic [2:0] nb1;
    logic [2:0] need;
    next_s = s;
    nb1 = s.nb + 3'h1;
    need = 3'h0;
    next_s.done = 1'b0;
    next_s.illegal = 1'b0;
    if (load_we) begin
      next_s.mem[load_addr] = load_data;
    end
    case (s.st)
      ST_FETCH: begin
        if (fetch_ack) begin
          next_s.pc = s.pc + 16'h0001;
          next_s.nb = nb1;
          if (s.nb == 3'h0 && fetch_data == OPC_PFX) begin
            next_s.pfx = 1'b1;
          end else if (!s.have_op) begin
            next_s.op = fetch_data;
            next_s.have_op = 1'b1;
          end else begin
            next_s.opr[2'(s.nb - 3'h1 - {2'b00, s.pfx})] = fetch_data;
          end
          if (next_s.have_op) begin
            need = f_len(next_s.pfx, next_s.op);
            if (need == 3'h0) begin
              // unknown opcode: drop it and restart at the next byte
              next_s.illegal = 1'b1;
              next_s.nb = 3'h0;
              next_s.pfx = 1'b0;
              next_s.have_op = 1'b0;
            end else if (nb1 == need) begin
              next_s.st = ST_EXEC;
              next_s.cnt = f_cyc(next_s.op);
            end
          end
        end
      end
      ST_EXEC: begin
        next_s.cnt = s.cnt - 3'h1;
        if (commit) begin
          next_s.st = ST_FETCH;
          next_s.nb = 3'h0;
          next_s.pfx = 1'b0;
          next_s.have_op = 1'b0;
          next_s.done = 1'b1;
          next_s.flags = alu_bus.fout;
          // a write from the load port in the same cycle loses to the commit
          if (alu_bus.wr && alu_bus.aop == AOP_SUBTRACT_ONE_WORD) begin
            next_s.mem[pair_a] = alu_bus.wres[15:8];
            next_s.mem[pair_a | 8'h01] = alu_bus.wres[7:0];
          end else if (alu_bus.wr) begin
            next_s.mem[dst_a] = alu_bus.res;
          end
          if (s.op == OPC_DI) begin
            next_s.irq_ctl[IRQ_EN_BIT] = 1'b0;
          end
        end
      end
      default: next_s.st = ST_FETCH;
    endcase
    // an enable request in the same cycle as the clear wins
    if (irq_enable_set) begin
      next_s.irq_ctl[IRQ_EN_BIT] = 1'b1;
    end
    next_s.peek = next_s.mem[peek_addr];
  end

  // one register stage for all state; reset clears the memory along with the rest
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= ST_FETCH;
      s.pc <= PC_RST;
      s.flags <= FLAGS_RST;
      s.irq_ctl <= INTERRUPT_CONTROL_REG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign fetch_req = (s.st == ST_FETCH);
  assign fetch_addr = s.pc;
  assign peek_data = s.peek;
  assign flags = s.flags;
  assign interrupt_control_reg = s.irq_ctl;
  assign instr_done = s.done;
  assign illegal_op = s.illegal;

  // cycles spent in the execute state, for the checks below
  logic [2:0] age;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      age <= 3'h0;
    end else begin
      age <= (s.st == ST_EXEC) ? age + 3'h1 : 3'h0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  clr_flags_a: assert property (commit && alu_bus.aop == AOP_CLR |=>
    flags == $past(flags) && instr_done) else $error("clear changed a flag");
  clr_cycles_a: assert property (commit && s.op == OPC_CLR_IR |-> age == 3'h2)
    else $error("indirect clear wrong cycle count");
  com_flags_a: assert property (commit && alu_bus.aop == AOP_COM |=>
    !flags[FLAG_V] && flags[FLAG_C] == $past(flags[FLAG_C])) else $error("invert flags wrong");
  cp_nostore_a: assert property (commit && alu_bus.aop == AOP_CP && !load_we |=>
    s.mem == $past(s.mem)) else $error("compare stored a result");
  cpc_len_a: assert property ($rose(s.st == ST_EXEC) && s.pfx && s.op == OPC_CP_R_R |->
    s.nb == 3'h4) else $error("prefixed compare byte count wrong");
  cpx_cycles_a: assert property (commit && s.op == OPC_CPX_ER |->
    age == 3'h2 && s.nb == (s.pfx ? 3'h5 : 3'h4)) else $error("extended compare timing wrong");
  compare_carry_extended_len_a: assert property ($rose(s.st == ST_EXEC) && s.pfx && s.op == OPC_CPX_IM |->
    s.nb == 3'h5 ##3 instr_done) else $error("carry extended compare length wrong");
  da_keep_a: assert property (commit && alu_bus.aop == AOP_DA |=>
    flags[FLAG_D] == $past(flags[FLAG_D]) && flags[FLAG_H] == $past(flags[FLAG_H]))
    else $error("decimal adjust disturbed D or H");
  dec_carry_a: assert property (commit && alu_bus.aop == AOP_DEC |=>
    flags[FLAG_C] == $past(flags[FLAG_C])) else $error("decrement changed carry");
  subtract_one_word_cycles_a: assert property (commit && s.op == OPC_SUBTRACT_ONE_WORD_IRR |-> age == 3'h5)
    else $error("indirect word decrement cycle count wrong");
  di_clear_a: assert property (commit && s.op == OPC_DI && !irq_enable_set |=>
    !interrupt_control_reg[IRQ_EN_BIT] && $stable(flags)) else $error("interrupts_off failed");

  cpc_run_c: cover property (commit && alu_bus.aop == AOP_CPC);
  subtract_one_word_run_c: cover property (commit && alu_bus.aop == AOP_SUBTRACT_ONE_WORD);
  di_run_c: cover property (commit && s.op == OPC_DI);
  illegal_c: cover property (illegal_op);
endmodule

// [sim/cacd_prog_mem.sv]
`timescale 1ns/1ns
// program memory on the far side of the fetch port
module cacd_prog_mem (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic halt,
  input wire logic slow,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic [7:0] fetch_data,
  output logic fetch_ack
);
  logic [7:0] mem [0:63];
  logic wait_q;

  // slow mode holds off the byte on every other cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= slow & ~wait_q;
    end
  end

  // halt lets the bench preload the register file before any byte moves
  assign fetch_ack = fetch_req & ~halt & ~wait_q;
  // the bus shows the inverse when no byte is offered, so stale data never matches
  assign fetch_data = fetch_ack ? mem[fetch_addr[5:0]] : ~mem[fetch_addr[5:0]];
endmodule

// [sim/cacd_core_test.sv]
`timescale 1ns/1ns
module cacd_core_test;
  import cacd_pkg::*;
  typedef struct packed {
    logic [39:0] prog;
    logic [2:0] len;
    logic [47:0] pre;
    logic [7:0] pa;
    logic [7:0] pv;
    logic [7:0] fl;
    logic [7:0] m;
    logic [2:0] cyc;
  } cacd_row_s;

  logic clock, reset_n, halt, slow, fetch_req, fetch_ack, load_we, irq_enable_set;
  logic instr_done, illegal_op;
  logic [15:0] fetch_addr;
  logic [7:0] fetch_data, load_addr, load_data, peek_addr, peek_data, flags, icr;
  int err_total, n_tests, cyc;
  cacd_row_s rows [0:26];
  cacd_row_s chain [0:7];
  logic [7:0] chain_code [0:22];
  logic [15:0] chain_pre [0:6];

  cacd_core dut_u (.clock(clock), .reset_n(reset_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data), .fetch_ack(fetch_ack),
    .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .irq_enable_set(irq_enable_set), .peek_addr(peek_addr), .peek_data(peek_data),
    .flags(flags), .interrupt_control_reg(icr), .instr_done(instr_done),
    .illegal_op(illegal_op));

  cacd_prog_mem mem_u (.clock(clock), .reset_n(reset_n), .halt(halt), .slow(slow),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .fetch_ack(fetch_ack));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: fetch address %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: execute cycles %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // reset for four cycles with the memory halted and cleared
  task automatic reset_dut();
    halt = 1'b1;
    reset_n = 1'b0;
    for (int i = 0; i < 64; i++) mem_u.mem[i] = 8'h00;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
  endtask

  task automatic load_pair(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    load_we = 1'b1;
    load_addr = a;
    load_data = v;
    @(negedge clock);
    load_we = 1'b0;
  endtask

  // counts cycles with the fetch port idle until the completion pulse
  task automatic run_one(output int n);
    int k;
    n = 0;
    k = 0;
    @(negedge clock);
    while (instr_done !== 1'b1 && k < 60) begin
      if (fetch_req === 1'b0) n++;
      k++;
      @(negedge clock);
    end
    if (k >= 60) begin
      err_total++;
      $display("CHECK FAILED at %0t: no completion seen", $time);
    end
  endtask

  // cut a hang short well past the expected run of about 550 cycles
  initial begin
    #1000000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    reset_n = 1'b0;
    halt = 1'b1;
    slow = 1'b0;
    load_we = 1'b0;
    load_addr = 8'h00;
    load_data = 8'h00;
    irq_enable_set = 1'b0;
    peek_addr = 8'h00;
    // program bytes, length, preloads, peek place and value, flags, mask, cycles
    rows = '{
      '{40'hB010000000, 2, 48'h105500000000, 8'h10, 8'h00, 8'h00, 8'hFF, 2},
      '{40'hB120000000, 2, 48'h203030AA0000, 8'h30, 8'h00, 8'h00, 8'hFF, 3},
      '{40'h6010000000, 2, 48'h100F00000000, 8'h10, 8'hF0, 8'h20, 8'hFF, 2},
      '{40'h6120000000, 2, 48'h204040FF0000, 8'h40, 8'h00, 8'h40, 8'hFF, 3},
      '{40'hA234000000, 2, 48'hE301E4020000, 8'hE3, 8'h01, 8'hA0, 8'hFF, 3},
      '{40'hA312000000, 2, 48'hE110E2505010, 8'hE1, 8'h10, 8'h40, 8'hFF, 4},
      '{40'hA411100000, 3, 48'h118010010000, 8'h10, 8'h01, 8'hB0, 8'hFF, 3},
      '{40'hA521100000, 3, 48'h216060031003, 8'h10, 8'h03, 8'h40, 8'hFF, 4},
      '{40'hA610050000, 3, 48'h100500000000, 8'h10, 8'h05, 8'h40, 8'hFF, 3},
      '{40'hA720FF0000, 3, 48'h2040407F0000, 8'h40, 8'h7F, 8'hB0, 8'hFF, 4},
      '{40'h1FA2340000, 3, 48'hE301E4020000, 8'hE3, 8'h01, 8'hA0, 8'hFF, 3},
      '{40'h1FA3120000, 3, 48'hE110E2505010, 8'hE1, 8'h10, 8'h40, 8'hFF, 4},
      '{40'h1FA4111000, 4, 48'h118010010000, 8'h10, 8'h01, 8'hB0, 8'hFF, 3},
      '{40'h1FA5211000, 4, 48'h216060031003, 8'h10, 8'h03, 8'h40, 8'hFF, 4},
      '{40'h1FA6100500, 4, 48'h100500000000, 8'h10, 8'h05, 8'h40, 8'hFF, 3},
      '{40'h1FA720FF00, 4, 48'h2040407F0000, 8'h40, 8'h7F, 8'hB0, 8'hFF, 4},
      '{40'hA801101000, 4, 48'h110110000000, 8'h10, 8'h00, 8'hA0, 8'hFF, 3},
      '{40'hA97FF01000, 4, 48'h108000000000, 8'h10, 8'h80, 8'h10, 8'hFF, 3},
      '{40'h1FA8011010, 5, 48'h110110000000, 8'h10, 8'h00, 8'hA0, 8'hFF, 3},
      '{40'h1FA97FF010, 5, 48'h108000000000, 8'h10, 8'h80, 8'h10, 8'hFF, 3},
      '{40'h4010000000, 2, 48'h109A00000000, 8'h10, 8'h00, 8'hC0, 8'hEF, 2},
      '{40'h4120000000, 2, 48'h2040400B0000, 8'h40, 8'h11, 8'h00, 8'hEF, 3},
      '{40'h3010000000, 2, 48'h108000000000, 8'h10, 8'h7F, 8'h10, 8'hFF, 2},
      '{40'h3120000000, 2, 48'h204040010000, 8'h40, 8'h00, 8'h40, 8'hFF, 3},
      '{40'h8011000000, 2, 48'h108011000000, 8'h10, 8'h7F, 8'h10, 8'hFF, 5},
      '{40'h8120000000, 2, 48'h203030003101, 8'h31, 8'h00, 8'h40, 8'hFF, 6},
      '{40'h8F00000000, 1, 48'h000000000000, 8'h00, 8'h00, 8'h00, 8'hFF, 2}
    };
    // one instruction per row from a fresh reset
    foreach (rows[r]) begin
      reset_dut();
      for (int i = 0; i < 5; i++) mem_u.mem[i] = rows[r].prog[39 - 8 * i -: 8];
      for (int p = 0; p < 3; p++) load_pair(rows[r].pre[47 - 16 * p -: 8], rows[r].pre[39 - 16 * p -: 8]);
      peek_addr = rows[r].pa;
      halt = 1'b0;
      run_one(cyc);
      check_count(cyc, int'(rows[r].cyc));
      check_byte(flags & rows[r].m, rows[r].fl & rows[r].m, "flags");
      check_byte(peek_data, rows[r].pv, "result");
      check_word(fetch_addr, {13'h0000, rows[r].len});
      halt = 1'b1;
    end
    // interrupt enable set by the input pulse, then cleared by the instruction
    reset_dut();
    mem_u.mem[0] = OPC_DI;
    @(negedge clock);
    irq_enable_set = 1'b1;
    @(negedge clock);
    irq_enable_set = 1'b0;
    @(negedge clock);
    check_byte(icr, 8'h80, "interrupt control before");
    halt = 1'b0;
    run_one(cyc);
    check_byte(icr, 8'h00, "interrupt control after");
    check_byte(flags, 8'h00, "flags after interrupts off");
    // an unknown opcode is skipped with a pulse; the next byte runs as an opcode
    reset_dut();
    check_byte(flags, FLAGS_RST, "flags after reset");
    check_byte({7'h00, illegal_op}, 8'h00, "no illegal pulse in reset");
    mem_u.mem[0] = 8'h00;
    mem_u.mem[1] = OPC_DI;
    halt = 1'b0;
    @(negedge clock);
    check_byte({7'h00, illegal_op}, 8'h01, "illegal opcode pulse");
    run_one(cyc);
    check_count(cyc, int'(CYC_DI));
    check_word(fetch_addr, 16'h0002);
    halt = 1'b1;
    // chained program over a stalling memory: carry survives and feeds the carry compares
    chain_code = '{8'hA6, 8'h10, 8'h01, 8'hB0, 8'h12, 8'h60, 8'h13, 8'h30, 8'h14, 8'h80,
      8'h16, 8'h1F, 8'hA6, 8'h15, 8'h04, 8'hA6, 8'h10, 8'h01, 8'h1F, 8'hA9, 8'h04,
      8'h00, 8'h15};
    chain_pre = '{16'h1233, 16'h1300, 16'h1481, 16'h1600, 16'h1701, 16'h1505, 16'h1000};
    chain = '{
      '{40'h0, 0, 48'h0, 8'h10, 8'h00, 8'hA0, 8'hFF, 3},
      '{40'h0, 0, 48'h0, 8'h12, 8'h00, 8'hA0, 8'hFF, 2},
      '{40'h0, 0, 48'h0, 8'h13, 8'hFF, 8'hA0, 8'hFF, 2},
      '{40'h0, 0, 48'h0, 8'h14, 8'h80, 8'hA0, 8'hFF, 2},
      '{40'h0, 0, 48'h0, 8'h17, 8'h00, 8'hC0, 8'hFF, 5},
      '{40'h0, 0, 48'h0, 8'h15, 8'h05, 8'h40, 8'hFF, 3},
      '{40'h0, 0, 48'h0, 8'h10, 8'h00, 8'hA0, 8'hFF, 3},
      '{40'h0, 0, 48'h0, 8'h15, 8'h05, 8'h40, 8'hFF, 3}
    };
    reset_dut();
    foreach (chain_code[i]) mem_u.mem[i] = chain_code[i];
    foreach (chain_pre[i]) load_pair(chain_pre[i][15:8], chain_pre[i][7:0]);
    slow = 1'b1;
    halt = 1'b0;
    foreach (chain[s]) begin
      peek_addr = chain[s].pa;
      run_one(cyc);
      check_count(cyc, int'(chain[s].cyc));
      check_byte(flags, chain[s].fl, "chained flags");
      check_byte(peek_data, chain[s].pv, "chained result");
    end
    slow = 1'b0;
    finish_test();
  end
endmodule
